/* File: design/rtc_pkg.sv */
// shared constants for the rtc time and date counter group
package rtc_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SCRATCH = 8'h03;
    localparam logic [7:0] ADDR_SECONDS = 8'h04;
    localparam logic [7:0] ADDR_MINUTES = 8'h05;
    localparam logic [7:0] ADDR_HOURS = 8'h06;
    localparam logic [7:0] ADDR_DATE = 8'h07;
    localparam logic [7:0] ADDR_MONTH = 8'h09;
    localparam logic [7:0] ADDR_YEAR = 8'h0a;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int OSC_STOP_BIT = 7;
    localparam int AFTERNOON_BIT = 5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SCRATCH = 8'h00;
    localparam logic [6:0] RST_SECONDS = 7'h00;
    localparam logic RST_OSC_STOP = 1'b1;
    localparam logic [6:0] RST_MINUTES = 7'h00;
    localparam logic [5:0] RST_HOURS = 6'h00;
    localparam logic [5:0] RST_DATE = 6'h01;
    localparam logic [4:0] RST_MONTH = 5'h01;
    localparam logic [7:0] RST_YEAR = 8'h00;

    // ------------------------------------------------------------
    // counter limits (bcd) and timing
    // ------------------------------------------------------------
    localparam logic [6:0] BCD_59 = 7'h59;
    localparam logic [5:0] BCD_23 = 6'h23;
    localparam logic [4:0] BCD_11 = 5'h11;
    localparam logic [4:0] BCD_12 = 5'h12;
    localparam logic [4:0] BCD_01 = 5'h01;
    localparam logic [7:0] BCD_99 = 8'h99;
    localparam int XTAL_EDGES_PER_SECOND = 32768;
endpackage

/* File: design/rtc_sec_prescaler.sv */
// crystal edge synchroniser and divider producing a one-second tick
module rtc_sec_prescaler #(
    parameter int DIVIDE = 32768
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic xtalClk,
    output logic secTick
);
    // ------------------------------------------------------------
    // synchroniser and edge detect
    // ------------------------------------------------------------
    logic xtalMeta_reg;
    logic xtalSync_reg;
    logic xtalLast_reg;
    logic [31:0] edgeCnt_reg;
    logic xtalRise;

    // crystal runs on its own clock, so two flops before any use
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            xtalMeta_reg <= 1'b0;
            xtalSync_reg <= 1'b0;
            xtalLast_reg <= 1'b0;
        end else begin
            xtalMeta_reg <= xtalClk;
            xtalSync_reg <= xtalMeta_reg;
            xtalLast_reg <= xtalSync_reg;
        end
    end

    assign xtalRise = xtalSync_reg && !xtalLast_reg;

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    // a stopped crystal simply freezes the count; no tick is faked
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            edgeCnt_reg <= 32'h0000_0000;
            secTick <= 1'b0;
        end else begin
            secTick <= 1'b0;
            if (xtalRise) begin
                if (edgeCnt_reg == 32'(DIVIDE - 1)) begin
                    edgeCnt_reg <= 32'h0000_0000;
                    secTick <= 1'b1;
                end else begin
                    edgeCnt_reg <= edgeCnt_reg + 32'h0000_0001;
                end
            end
        end
    end
endmodule

/* File: design/rtc_time_date_counters.sv */
// bcd time and date counters with scratch byte and oscillator stop flag
// Behaviour
// R01 - scratch byte at 03h, resets zero
// R02 - seconds bcd 00 to 59 at 04h
// R03 - oscillator stop flag bit 7, set at reset
// R04 - minutes bcd 00 to 59, bit 7 zero
// R05 - 24-hour mode hours 0 to 23
// R06 - 12-hour mode hours 1 to 12
// R07 - bit 5 is afternoon in 12-hour mode
// R08 - date 01 to 31, resets to 01
// R09 - date rollover with leap-year february
// R10 - year bcd 00 to 99 drives leap
// R11 - one-second carry chain through date
module rtc_time_date_counters
    import rtc_pkg::*;
#(
    parameter int XTAL_DIVIDE = XTAL_EDGES_PER_SECOND
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic xtalClk,
    input wire logic oscStopped,
    input wire logic hourMode12,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic secondPulse
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // bcd increment of two digits, no limit check
    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v[3:0] >= 4'h9) begin
            r[3:0] = 4'h0;
            r[7:4] = v[7:4] + 4'h1;
        end else begin
            r[3:0] = v[3:0] + 4'h1;
        end
        return r;
    endfunction

    // last date of a month, bcd; year 00..99 means 2000..2099
    function automatic logic [5:0] lastDay(input logic [4:0] m,
                                           input logic [7:0] y);
        logic leap;
        leap = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 ||
                          y[3:0] == 4'h8)) ||
               (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6));
        case (m)
            5'h02: lastDay = leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: lastDay = 6'h30;
            default: lastDay = 6'h31;
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] scratch_reg;
    logic oscStop_reg;
    logic [6:0] seconds_reg;
    logic [6:0] minutes_reg;
    logic [5:0] hours_reg;
    logic [5:0] date_reg;
    logic [4:0] month_reg;
    logic [7:0] year_reg;
    logic oscMeta_reg;
    logic oscSync_reg;
    logic secTick;
    logic secWrap;
    logic minWrap;
    logic hourWrap;
    logic dateWrap;
    logic monthWrap;
    logic wrSec;
    logic wrMin;
    logic wrHour;
    logic wrDate;
    logic wrMonth;
    logic wrYear;
    logic [4:0] hour12;

    rtc_sec_prescaler #(
        .DIVIDE(XTAL_DIVIDE)
    ) u_prescaler (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .xtalClk(xtalClk),
        .secTick(secTick)
    );

    // host write strobes per register
    assign wrSec = regWrEn && regAddr == ADDR_SECONDS;
    assign wrMin = regWrEn && regAddr == ADDR_MINUTES;
    assign wrHour = regWrEn && regAddr == ADDR_HOURS;
    assign wrDate = regWrEn && regAddr == ADDR_DATE;
    assign wrMonth = regWrEn && regAddr == ADDR_MONTH;
    assign wrYear = regWrEn && regAddr == ADDR_YEAR;

    // carry chain; each stage only moves when the one below wraps
    assign hour12 = hours_reg[4:0];
    assign secWrap = secTick && seconds_reg == BCD_59; // see R11
    assign minWrap = secWrap && minutes_reg == BCD_59;
    assign hourWrap = minWrap && (hourMode12 ?
        (hour12 == BCD_11 && hours_reg[AFTERNOON_BIT]) :
        hours_reg == BCD_23);
    assign dateWrap = hourWrap && date_reg == lastDay(month_reg, year_reg);
    assign monthWrap = dateWrap && month_reg == BCD_12;

    // ------------------------------------------------------------
    // scratch byte
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            scratch_reg <= RST_SCRATCH; // see R01
        end else if (regWrEn && regAddr == ADDR_SCRATCH) begin
            scratch_reg <= regWrData; // see R01
        end
    end

    // ------------------------------------------------------------
    // oscillator stop flag
    // ------------------------------------------------------------
    // pin is asynchronous, so two flops before the flag logic
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            oscMeta_reg <= 1'b0;
            oscSync_reg <= 1'b0;
        end else begin
            oscMeta_reg <= oscStopped;
            oscSync_reg <= oscMeta_reg;
        end
    end

    // a stop event beats a clearing write in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            oscStop_reg <= RST_OSC_STOP; // see R03
        end else if (oscSync_reg) begin
            oscStop_reg <= 1'b1; // see R03
        end else if (wrSec) begin
            oscStop_reg <= regWrData[OSC_STOP_BIT];
        end
    end

    // ------------------------------------------------------------
    // seconds and minutes
    // ------------------------------------------------------------
    // host write wins over the tick for the written register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            seconds_reg <= RST_SECONDS;
        end else if (wrSec) begin
            seconds_reg <= regWrData[6:0];
        end else if (secWrap) begin
            seconds_reg <= 7'h00; // see R02
        end else if (secTick) begin
            seconds_reg <= 7'(bcdInc({1'b0, seconds_reg})); // see R11
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            minutes_reg <= RST_MINUTES;
        end else if (wrMin) begin
            minutes_reg <= regWrData[6:0]; // see R04
        end else if (minWrap) begin
            minutes_reg <= 7'h00; // see R04
        end else if (secWrap) begin
            minutes_reg <= 7'(bcdInc({1'b0, minutes_reg}));
        end
    end

    // ------------------------------------------------------------
    // hours, 12 or 24 hour format
    // ------------------------------------------------------------
    // switching format does not convert the stored value
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hours_reg <= RST_HOURS;
        end else if (wrHour) begin
            hours_reg <= regWrData[5:0];
        end else if (minWrap) begin
            if (!hourMode12) begin
                if (hours_reg == BCD_23) begin
                    hours_reg <= 6'h00; // see R05
                end else begin
                    hours_reg <= 6'(bcdInc({2'b00, hours_reg}));
                end
            end else if (hour12 == BCD_12) begin
                hours_reg[4:0] <= BCD_01; // see R06
            end else if (hour12 == BCD_11) begin
                hours_reg[4:0] <= BCD_12; // see R06
                hours_reg[AFTERNOON_BIT] <= !hours_reg[AFTERNOON_BIT];
                // see R07
            end else begin
                hours_reg[4:0] <= 5'(bcdInc({3'b000, hour12}));
            end
        end
    end

    // ------------------------------------------------------------
    // date, month, year
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            date_reg <= RST_DATE; // see R08
        end else if (wrDate) begin
            date_reg <= regWrData[5:0];
        end else if (dateWrap) begin
            date_reg <= RST_DATE; // see R09
        end else if (hourWrap) begin
            date_reg <= 6'(bcdInc({2'b00, date_reg})); // see R09
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            month_reg <= RST_MONTH;
        end else if (wrMonth) begin
            month_reg <= regWrData[4:0];
        end else if (monthWrap) begin
            month_reg <= BCD_01;
        end else if (dateWrap) begin
            month_reg <= 5'(bcdInc({3'b000, month_reg}));
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            year_reg <= RST_YEAR;
        end else if (wrYear) begin
            year_reg <= regWrData;
        end else if (monthWrap) begin
            // century is fixed, 99 wraps to 00
            year_reg <= (year_reg == BCD_99) ? 8'h00 : bcdInc(year_reg);
            // see R10
        end
    end

    // ------------------------------------------------------------
    // read port and tick output
    // ------------------------------------------------------------
    // one cycle of latency; unused bits and unmapped offsets read zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= 8'h00;
            secondPulse <= 1'b0;
        end else begin
            secondPulse <= secTick;
            case (regAddr)
                ADDR_SCRATCH: regRdData <= scratch_reg;
                ADDR_SECONDS: regRdData <= {oscStop_reg, seconds_reg};
                ADDR_MINUTES: regRdData <= {1'b0, minutes_reg}; // see R04
                ADDR_HOURS: regRdData <= {2'b00, hours_reg}; // see R05
                ADDR_DATE: regRdData <= {2'b00, date_reg}; // see R08
                ADDR_MONTH: regRdData <= {3'b000, month_reg};
                ADDR_YEAR: regRdData <= year_reg;
                default: regRdData <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_scratch_store;
        @(posedge ref_clk) disable iff (!arst_n)
        regWrEn && regAddr == ADDR_SCRATCH ##1 regAddr == ADDR_SCRATCH
        |=> regRdData == $past(regWrData, 2);
    endproperty
    a_scratch_store: assert property (p_scratch_store) // see R01
        else $error("scratch byte did not read back");

    property p_sec_wrap;
        @(posedge ref_clk) disable iff (!arst_n)
        secTick && seconds_reg == 7'h59 && !wrSec |=> seconds_reg == 7'h00;
    endproperty
    a_sec_wrap: assert property (p_sec_wrap) // see R02
        else $error("seconds did not wrap at 59");

    property p_osc_flag;
        @(posedge ref_clk) disable iff (!arst_n)
        $rose(oscStopped) |-> ##[2:3] oscStop_reg;
    endproperty
    a_osc_flag: assert property (p_osc_flag) // see R03
        else $error("stop flag not set after oscillator stop");

    property p_min_bit7;
        @(posedge ref_clk) disable iff (!arst_n)
        regAddr == ADDR_MINUTES |=> !regRdData[7];
    endproperty
    a_min_bit7: assert property (p_min_bit7) // see R04
        else $error("minutes bit 7 read as one");

    property p_hour24_wrap;
        @(posedge ref_clk) disable iff (!arst_n)
        minWrap && !hourMode12 && hours_reg == 6'h23 && !wrHour
        |=> hours_reg == 6'h00 && $changed(date_reg);
    endproperty
    a_hour24_wrap: assert property (p_hour24_wrap) // see R05
        else $error("24-hour wrap wrong");

    property p_hour12_wrap;
        @(posedge ref_clk) disable iff (!arst_n)
        minWrap && hourMode12 && hour12 == 5'h12 && !wrHour
        |=> hours_reg[4:0] == 5'h01 && $stable(hours_reg[AFTERNOON_BIT]);
    endproperty
    a_hour12_wrap: assert property (p_hour12_wrap) // see R06
        else $error("12 did not become 1");

    property p_afternoon_toggle;
        @(posedge ref_clk) disable iff (!arst_n)
        minWrap && hourMode12 && hour12 == 5'h11 && !wrHour
        |=> hours_reg[4:0] == 5'h12 && $changed(hours_reg[AFTERNOON_BIT]);
    endproperty
    a_afternoon_toggle: assert property (p_afternoon_toggle) // see R07
        else $error("afternoon indicator did not toggle at 12");

    property p_date_top;
        @(posedge ref_clk) disable iff (!arst_n)
        regAddr == ADDR_DATE |=> regRdData[7:6] == 2'b00;
    endproperty
    a_date_top: assert property (p_date_top) // see R08
        else $error("date unused bits nonzero");

    property p_leap_feb;
        @(posedge ref_clk) disable iff (!arst_n)
        hourWrap && date_reg == 6'h28 && month_reg == 5'h02 &&
        year_reg == 8'h24 && !wrDate |=> date_reg == 6'h29;
    endproperty
    a_leap_feb: assert property (p_leap_feb) // see R09
        else $error("leap february skipped the 29th");

    property p_year_wrap;
        @(posedge ref_clk) disable iff (!arst_n)
        monthWrap && year_reg == 8'h99 && !wrYear |=> year_reg == 8'h00;
    endproperty
    a_year_wrap: assert property (p_year_wrap) // see R10
        else $error("year did not wrap at 99");

    property p_sec_step;
        @(posedge ref_clk) disable iff (!arst_n)
        secTick && seconds_reg == 7'h09 && !wrSec
        |=> seconds_reg == 7'h10 && secondPulse ##1 !secondPulse;
    endproperty
    a_sec_step: assert property (p_sec_step) // see R11
        else $error("seconds bcd step wrong");
endmodule

/* File: verif/rtc_host_model.sv */
// host side model driving the decoded register port of the counters
module rtc_host_model (
    input wire logic ref_clk,
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    // idle data is never left at the last value written
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    // one-cycle strobe, data released to its inverse after the edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        regAddr = a;
        regWrEn = 1'b1;
        regWrData = d;
        @(posedge ref_clk);
        #1;
        regWrEn = 1'b0;
        regWrData = ~d;
    endtask

    // address sampled at one edge, data stands after it
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        regAddr = a;
        @(posedge ref_clk);
        #1;
        d = regRdData;
    endtask
endmodule

/* File: verif/rtc_time_date_counters_tb_top.sv */
// self-checking bench for the time and date counter group
`define CHK(nm, exp, got) \
    begin \
        nChecks++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("wrong value %s expected %h seen %h", nm, exp, got); \
        end \
    end

module rtc_time_date_counters_tb_top
    import rtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // short divide keeps one second at about 160 clocks
    localparam int DIV = 4;
    localparam int WATCH_CYCLES = 40000;

    typedef struct {
        logic [7:0] addr;
        logic [7:0] wr;
        logic [7:0] exp;
    } rtc_row_t;

    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic xtalClk = 1'b0;
    logic xtalRun = 1'b0;
    logic oscStopped = 1'b0;
    logic hourMode12 = 1'b0;
    logic [7:0] regAddr;
    logic regWrEn;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic secondPulse;
    int errors = 0;
    int nChecks = 0;

    rtc_row_t rows[9] = '{
        '{8'h03, 8'ha5, 8'ha5},
        '{8'h04, 8'h59, 8'h59},
        '{8'h04, 8'hd9, 8'hd9},
        '{8'h05, 8'hff, 8'h7f},
        '{8'h06, 8'hff, 8'h3f},
        '{8'h07, 8'hff, 8'h3f},
        '{8'h08, 8'h5a, 8'h00},   // unmapped place reads zero
        '{8'h09, 8'h12, 8'h12},
        '{8'h0a, 8'h99, 8'h99}
    };

    // ------------------------------------------------------------
    // clocks and instances
    // ------------------------------------------------------------
    always #5 ref_clk = ~ref_clk;

    // crystal stands low while stopped, phase unrelated to ref_clk
    always begin
        #200.3;
        xtalClk = xtalRun ? ~xtalClk : 1'b0;
    end

    rtc_time_date_counters #(.XTAL_DIVIDE(DIV)) dut (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .xtalClk(xtalClk),
        .oscStopped(oscStopped),
        .hourMode12(hourMode12),
        .regAddr(regAddr),
        .regWrEn(regWrEn),
        .regWrData(regWrData),
        .regRdData(regRdData),
        .secondPulse(secondPulse)
    );

    rtc_host_model host (
        .ref_clk(ref_clk),
        .regAddr(regAddr),
        .regWrEn(regWrEn),
        .regWrData(regWrData),
        .regRdData(regRdData)
    );

    // ------------------------------------------------------------
    // helper tasks
    // ------------------------------------------------------------
    task automatic check_reg(input string nm, input logic [7:0] a,
                             input logic [7:0] exp);
        logic [7:0] got;
        host.read_reg(a, got);
        `CHK(nm, exp, got)
    endtask

    task automatic set_all(input logic [7:0] y, input logic [7:0] mo,
                           input logic [7:0] d, input logic [7:0] h,
                           input logic [7:0] m, input logic [7:0] s);
        host.write_reg(ADDR_YEAR, y);
        host.write_reg(ADDR_MONTH, mo);
        host.write_reg(ADDR_DATE, d);
        host.write_reg(ADDR_HOURS, h);
        host.write_reg(ADDR_MINUTES, m);
        host.write_reg(ADDR_SECONDS, s);
    endtask

    // runs the crystal for exactly one second, bounded wait
    task automatic tick_once;
        int k;
        k = 0;
        xtalRun = 1'b1;
        @(posedge ref_clk);
        #1;
        while (secondPulse !== 1'b1 && k < 2000) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        xtalRun = 1'b0;
        `CHK("second pulse", 1'b1, secondPulse)
        // the pulse stands for exactly one clock
        @(posedge ref_clk);
        #1;
        `CHK("pulse width", 1'b0, secondPulse)
    endtask

    task finish_test;
        $display("checks %0d errors %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        #(WATCH_CYCLES * 10);
        errors++;
        finish_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        // table rows, crystal stopped so nothing moves under us
        foreach (rows[i]) begin
            host.write_reg(rows[i].addr, rows[i].wr);
            check_reg("row read", rows[i].addr, rows[i].exp);
        end
        // plain second and bcd digit carry
        set_all(8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h09);
        tick_once();
        check_reg("sec digit carry", ADDR_SECONDS, 8'h10);
        // full chain through the end of 2099
        set_all(8'h99, 8'h12, 8'h31, 8'h23, 8'h59, 8'h59);
        tick_once();
        check_reg("sec wrap", ADDR_SECONDS, 8'h00);
        check_reg("min wrap", ADDR_MINUTES, 8'h00);
        check_reg("hour wrap", ADDR_HOURS, 8'h00);
        check_reg("date wrap", ADDR_DATE, 8'h01);
        check_reg("month wrap", ADDR_MONTH, 8'h01);
        check_reg("year wrap", ADDR_YEAR, 8'h00);
        // leap year february gains its 29th, plain year 23 ends on the 28th
        set_all(8'h24, 8'h02, 8'h28, 8'h23, 8'h59, 8'h59);
        tick_once();
        check_reg("leap 29th", ADDR_DATE, 8'h29);
        set_all(8'h24, 8'h02, 8'h29, 8'h23, 8'h59, 8'h59);
        tick_once();
        check_reg("leap end", ADDR_DATE, 8'h01);
        check_reg("leap month", ADDR_MONTH, 8'h03);
        set_all(8'h23, 8'h02, 8'h28, 8'h23, 8'h59, 8'h59);
        tick_once();
        check_reg("plain feb end", ADDR_DATE, 8'h01);
        // 12-hour sequence: 11 am to 12 pm, 12 pm to 1 pm, 11 pm on
        @(posedge ref_clk);
        #1;
        hourMode12 = 1'b1;
        set_all(8'h00, 8'h01, 8'h05, 8'h11, 8'h59, 8'h59);
        tick_once();
        check_reg("noon", ADDR_HOURS, 8'h32);
        check_reg("no date carry", ADDR_DATE, 8'h05);
        set_all(8'h00, 8'h01, 8'h05, 8'h32, 8'h59, 8'h59);
        tick_once();
        check_reg("one pm", ADDR_HOURS, 8'h21);
        set_all(8'h00, 8'h01, 8'h05, 8'h31, 8'h59, 8'h59);
        tick_once();
        check_reg("midnight", ADDR_HOURS, 8'h12);
        check_reg("date carry", ADDR_DATE, 8'h06);
        // stop flag: monitor sets it and beats a clearing write
        host.write_reg(ADDR_SECONDS, 8'h00);
        check_reg("flag clear", ADDR_SECONDS, 8'h00);
        @(posedge ref_clk);
        #1;
        oscStopped = 1'b1;
        repeat (6) @(posedge ref_clk);
        check_reg("flag set", ADDR_SECONDS, 8'h80);
        host.write_reg(ADDR_SECONDS, 8'h15);
        check_reg("set wins", ADDR_SECONDS, 8'h95);
        @(posedge ref_clk);
        #1;
        oscStopped = 1'b0;
        repeat (6) @(posedge ref_clk);
        host.write_reg(ADDR_SECONDS, 8'h15);
        check_reg("flag cleared", ADDR_SECONDS, 8'h15);
        // second reset in mid-run restores the defaults
        @(posedge ref_clk);
        #1;
        hourMode12 = 1'b0;
        arst_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK("read in reset", 8'h00, regRdData)
        `CHK("pulse in reset", 1'b0, secondPulse)
        arst_n = 1'b1;
        check_reg("scratch rst", ADDR_SCRATCH, 8'h00);
        check_reg("seconds rst", ADDR_SECONDS, 8'h80);
        check_reg("minutes rst", ADDR_MINUTES, 8'h00);
        check_reg("hours rst", ADDR_HOURS, 8'h00);
        check_reg("date rst", ADDR_DATE, 8'h01);
        finish_test();
    end
endmodule
